/* File: rtl/rx_latency_defines.svh */
// Register offsets, reset values and fixed counts of the receive latency and transport block
`ifndef RX_LATENCY_DEFINES_SVH
`define RX_LATENCY_DEFINES_SVH
`define OFS_LINK_CTRL 12'h300
`define OFS_LATENCY 12'h302
`define OFS_MF_DELAY 12'h304
`define OFS_DELAY_VAR 12'h306
`define OFS_L_M1 12'h453
`define OFS_F_M1 12'h454
`define OFS_K_M1 12'h455
`define OFS_M_M1 12'h456
`define OFS_N_M1 12'h457
`define OFS_NP_SUBCLASS 12'h458
`define OFS_S_JESDV 12'h459
`define OFS_HD 12'h45A
`define POS_LINK_EN 0
`define POS_HD 7
`define RST_LINK_CTRL 8'h00
`define RST_MF_DELAY 8'h00
`define RST_DELAY_VAR 8'h00
`define RST_L_M1 5'h07
`define RST_F_M1 8'h00
`define RST_K_M1 5'h1F
`define RST_M_M1 8'h01
`define RST_N_M1 5'h0F
`define RST_NP_M1 5'h0F
`define RST_SUBCLASS 3'h1
`define RST_S_M1 5'h01
`define RST_JESDV 3'h1
`define RST_HD 1'b1
`define FRAMES_PER_MF 8'h20
`define RBD_MAX 8'h0A
`define NUM_LANES 8
`define BUF_DEPTH 64
`define BUF_PTR_W 6
`endif

/* File: rtl/rx_latency_pkg.sv */
// Types shared by the receive latency and transport block
package rx_latency_pkg;
   typedef struct packed {
      logic [4:0] l_m1;
      logic [7:0] f_m1;
      logic [4:0] k_m1;
      logic [7:0] m_m1;
      logic [4:0] n_m1;
      logic [4:0] np_m1;
      logic [2:0] subclass;
      logic [4:0] s_m1;
      logic [2:0] jesdv;
      logic hd;
   } cfg_t;
   typedef logic [7:0][15:0] conv_samples_t;
   typedef struct packed {
      conv_samples_t c1;
      conv_samples_t c0;
   } samples_t;
   typedef logic [7:0][31:0] lane_words_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HOLD, ST_STREAM} release_state_t;
endpackage

/* File: rtl/lane_buffer.sv */
// Per-lane receive buffer that holds words until the common release
`timescale 1ns/1ps
`include "rx_latency_defines.svh"
module lane_buffer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   output logic empty,
   output logic started
);
   logic [31:0] mem [0:`BUF_DEPTH-1];
   logic [`BUF_PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [`BUF_PTR_W:0] count, next_count;
   logic next_started;
   logic do_wr, do_rd;

   // Overflow drops the word rather than corrupting the read side
   always_comb begin
      do_wr = wr_en && (count < (`BUF_PTR_W+1)'(`BUF_DEPTH));
      do_rd = rd_en && (count != '0);
      next_wr_ptr = flush ? '0 : wr_ptr + `BUF_PTR_W'(do_wr);
      next_rd_ptr = flush ? '0 : rd_ptr + `BUF_PTR_W'(do_rd);
      next_count = flush ? '0 : count + (`BUF_PTR_W+1)'(do_wr) - (`BUF_PTR_W+1)'(do_rd);
      next_started = flush ? 1'b0 : (started | wr_en);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         started <= 1'b0;
         rd_data <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         started <= next_started;
         if (do_rd) begin
            rd_data <= mem[rd_ptr];
         end
      end
   end

   // Storage has no reset; only pointers define what is valid
   always_ff @(posedge clk) begin
      if (do_wr && !flush) begin
         mem[wr_ptr] <= wr_data;
      end
   end

   assign empty = (count == '0);
endmodule

/* File: rtl/rx_latency_transport.sv */
// Deterministic-latency release and transport mapping for one receive link
`timescale 1ns/1ps
`include "rx_latency_defines.svh"
module rx_latency_transport
   import rx_latency_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rdata,
   input wire logic lmfc_edge,
   input wire logic [4:0] cfg_cf,
   input wire logic [1:0] cfg_cs,
   input wire logic [`NUM_LANES-1:0] lane_valid,
   input wire lane_words_t lane_data,
   output logic local_multiframe_clock,
   output logic samples_valid,
   output samples_t samples,
   output logic config_error,
   output logic buffer_underrun
);
   // Register file
   logic [7:0] link_ctrl, next_link_ctrl;
   logic [7:0] multiframe_delay, next_multiframe_delay;
   logic [7:0] delay_variation_window, next_delay_variation_window;
   logic [7:0] link_latency_readback, next_link_latency_readback;
   cfg_t cfg, next_cfg;
   logic [7:0] next_reg_rdata;
   logic link_en;

   // Multiframe timing
   logic [5:0] align_cnt, next_align_cnt;
   logic [5:0] local_cnt, next_local_cnt;
   logic [5:0] proc_cycles_per_multiframe;
   logic [5:0] delay_phase;
   logic [5:0] align_now;
   logic local_pulse;
   logic latency_taken, next_latency_taken;

   // Release control
   release_state_t state, next_state;
   logic [3:0] hold_cnt, next_hold_cnt;
   logic [3:0] rbd;
   logic next_buffer_underrun;
   logic rd_en, next_rd_pending, rd_pending;

   // Lane buffers and mapping
   logic [`NUM_LANES-1:0] lane_active, lane_empty, lane_started, wr_en;
   lane_words_t rd_words;
   cfg_t map_cfg, next_map_cfg;
   logic cfg_ok, next_config_error;
   samples_t next_samples;

   // Cycles per multiframe: K frames at 4/F frames per cycle gives 8*F
   function automatic logic [5:0] mf_cycles(input logic [7:0] f_m1);
      logic [7:0] tmp;
      tmp = (`FRAMES_PER_MF >> 2) * (f_m1 + 8'h01);
      return tmp[5:0];
   endfunction

   // Frame-to-sample unpacking for two converters
   function automatic samples_t unpack(input lane_words_t w, input cfg_t c);
      samples_t r;
      int f, l, o, fr, oo, j, k, cv, s, idx, nl, ns;
      logic [7:0] oct;
      r = '0;
      f = int'(c.f_m1) + 1;
      nl = int'(c.l_m1) + 1;
      ns = int'(c.s_m1) + 1;
      for (l = 0; l < `NUM_LANES; l++) begin
         for (o = 0; o < 4; o++) begin
            oct = w[l][31 - 8 * o -: 8];
            fr = o / f;
            oo = o % f;
            j = l * f + oo;
            k = j / 2;
            cv = k / ns;
            s = k % ns;
            idx = fr * ns + s;
            if (l < nl && idx < 8) begin
               if (cv == 0) begin
                  if (j % 2 == 0) r.c0[idx][15:8] = oct;
                  else r.c0[idx][7:0] = oct;
               end else if (cv == 1) begin
                  if (j % 2 == 0) r.c1[idx][15:8] = oct;
                  else r.c1[idx][7:0] = oct;
               end
            end
         end
      end
      return r;
   endfunction

   assign link_en = link_ctrl[`POS_LINK_EN];

   // Register writes and readback; latency register is read only
   always_comb begin
      next_link_ctrl = link_ctrl;
      next_multiframe_delay = multiframe_delay;
      next_delay_variation_window = delay_variation_window;
      next_cfg = cfg;
      if (reg_wr) begin
         case (reg_addr)
            `OFS_LINK_CTRL: next_link_ctrl = reg_wdata;
            `OFS_MF_DELAY: next_multiframe_delay = reg_wdata;
            `OFS_DELAY_VAR: next_delay_variation_window = reg_wdata;
            `OFS_L_M1: next_cfg.l_m1 = reg_wdata[4:0];
            `OFS_F_M1: next_cfg.f_m1 = reg_wdata;
            `OFS_K_M1: next_cfg.k_m1 = reg_wdata[4:0];
            `OFS_M_M1: next_cfg.m_m1 = reg_wdata;
            `OFS_N_M1: next_cfg.n_m1 = reg_wdata[4:0];
            `OFS_NP_SUBCLASS: begin
               next_cfg.np_m1 = reg_wdata[4:0];
               next_cfg.subclass = reg_wdata[7:5];
            end
            `OFS_S_JESDV: begin
               next_cfg.s_m1 = reg_wdata[4:0];
               next_cfg.jesdv = reg_wdata[7:5];
            end
            `OFS_HD: next_cfg.hd = reg_wdata[`POS_HD];
            default: ;
         endcase
      end
      case (reg_addr)
         `OFS_LINK_CTRL: next_reg_rdata = link_ctrl;
         `OFS_LATENCY: next_reg_rdata = link_latency_readback;
         `OFS_MF_DELAY: next_reg_rdata = multiframe_delay;
         `OFS_DELAY_VAR: next_reg_rdata = delay_variation_window;
         `OFS_L_M1: next_reg_rdata = {3'h0, cfg.l_m1};
         `OFS_F_M1: next_reg_rdata = cfg.f_m1;
         `OFS_K_M1: next_reg_rdata = {3'h0, cfg.k_m1};
         `OFS_M_M1: next_reg_rdata = cfg.m_m1;
         `OFS_N_M1: next_reg_rdata = {3'h0, cfg.n_m1};
         `OFS_NP_SUBCLASS: next_reg_rdata = {cfg.subclass, cfg.np_m1};
         `OFS_S_JESDV: next_reg_rdata = {cfg.jesdv, cfg.s_m1};
         `OFS_HD: next_reg_rdata = {cfg.hd, 7'h00};
         default: next_reg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link_ctrl <= `RST_LINK_CTRL;
         multiframe_delay <= `RST_MF_DELAY;
         delay_variation_window <= `RST_DELAY_VAR;
         cfg <= '{`RST_L_M1, `RST_F_M1, `RST_K_M1, `RST_M_M1, `RST_N_M1,
                  `RST_NP_M1, `RST_SUBCLASS, `RST_S_M1, `RST_JESDV, `RST_HD};
         reg_rdata <= 8'h00;
      end else begin
         link_ctrl <= next_link_ctrl;
         multiframe_delay <= next_multiframe_delay;
         delay_variation_window <= next_delay_variation_window;
         cfg <= next_cfg;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Settings are processing cycles; the period is a power of two so masking gives the modulo
   always_comb begin
      proc_cycles_per_multiframe = mf_cycles(map_cfg.f_m1);
      // Phase is zero in the aligned edge cycle itself, so a zero delay means no shift
      align_now = lmfc_edge ? 6'h00 : align_cnt;
      delay_phase = multiframe_delay[5:0] & (proc_cycles_per_multiframe - 6'h01);
      local_pulse = link_en && (align_now == delay_phase);
      if (align_now == proc_cycles_per_multiframe - 6'h01) next_align_cnt = '0;
      else next_align_cnt = align_now + 6'h01;
      // Count is one in the cycle after the pulse, so it equals the cycles since the pulse
      if (local_pulse) next_local_cnt = 6'h01;
      else if (local_cnt == proc_cycles_per_multiframe - 6'h01) next_local_cnt = '0;
      else next_local_cnt = local_cnt + 6'h01;
      // Latency wraps naturally at the multiframe period
      next_link_latency_readback = link_latency_readback;
      next_latency_taken = link_en ? latency_taken : 1'b0;
      if (link_en && !latency_taken && lane_valid[0]) begin
         next_link_latency_readback = {2'b00, local_pulse ? 6'h00 : local_cnt};
         next_latency_taken = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         align_cnt <= '0;
         local_cnt <= '0;
         link_latency_readback <= 8'h00;
         latency_taken <= 1'b0;
      end else begin
         align_cnt <= next_align_cnt;
         local_cnt <= next_local_cnt;
         link_latency_readback <= next_link_latency_readback;
         latency_taken <= next_latency_taken;
      end
   end

   assign local_multiframe_clock = local_pulse;

   // Release: wait for every active lane, then the local edge, then the buffer delay
   always_comb begin
      lane_active = '0;
      for (int i = 0; i < `NUM_LANES; i++) begin
         lane_active[i] = (5'(i) <= map_cfg.l_m1);
      end
      wr_en = lane_valid & lane_active & {`NUM_LANES{link_en}};
      if (delay_variation_window > `RBD_MAX) rbd = 4'(`RBD_MAX);
      else rbd = delay_variation_window[3:0];
      next_state = state;
      next_hold_cnt = hold_cnt;
      next_buffer_underrun = buffer_underrun;
      rd_en = 1'b0;
      case (state)
         ST_IDLE: begin
            next_buffer_underrun = 1'b0;
            if (link_en) next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if ((lane_started & lane_active) == lane_active && local_pulse) begin
               next_hold_cnt = rbd - 4'h1;
               next_state = (rbd == 4'h0) ? ST_STREAM : ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (hold_cnt == 4'h0) next_state = ST_STREAM;
            else next_hold_cnt = hold_cnt - 4'h1;
         end
         ST_STREAM: begin
            // One common strobe keeps lanes of a frame together
            if ((lane_empty & lane_active) != '0) next_buffer_underrun = 1'b1;
            else rd_en = 1'b1;
         end
         default: next_state = ST_IDLE;
      endcase
      if (!link_en) next_state = ST_IDLE;
      next_rd_pending = rd_en;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         hold_cnt <= 4'h0;
         buffer_underrun <= 1'b0;
         rd_pending <= 1'b0;
      end else begin
         state <= next_state;
         hold_cnt <= next_hold_cnt;
         buffer_underrun <= next_buffer_underrun;
         rd_pending <= next_rd_pending;
      end
   end

   for (genvar g = 0; g < `NUM_LANES; g++) begin : g_lane
      lane_buffer u_buf (
         .clk(clk),
         .rst_b(rst_b),
         .flush(!link_en),
         .wr_en(wr_en[g]),
         .wr_data(lane_data[g]),
         .rd_en(rd_en),
         .rd_data(rd_words[g]),
         .empty(lane_empty[g]),
         .started(lane_started[g])
      );
   end

   // Mapping only follows a supported parameter set while the link is disabled; otherwise the old one stays
   always_comb begin
      cfg_ok = (cfg.l_m1 == 5'h03 || cfg.l_m1 == 5'h07)
            && (cfg.f_m1 == 8'h00 || cfg.f_m1 == 8'h01 || cfg.f_m1 == 8'h03)
            && (cfg.k_m1 == 5'h1F) && (cfg.m_m1 == 8'h01)
            && (cfg.s_m1 == 5'h00 || cfg.s_m1 == 5'h01)
            && (cfg.n_m1 == 5'h0F) && (cfg.np_m1 == 5'h0F)
            && (cfg_cf == 5'h00) && (cfg_cs == 2'h0)
            && (cfg.hd == (cfg.f_m1 == 8'h00))
            && ((8'(cfg.l_m1) + 8'h01) * (cfg.f_m1 + 8'h01) == 8'h04 * (8'(cfg.s_m1) + 8'h01));
      next_map_cfg = (cfg_ok && !link_en) ? cfg : map_cfg;
      next_config_error = !cfg_ok;
      next_samples = rd_pending ? unpack(rd_words, map_cfg) : samples;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         map_cfg <= '{`RST_L_M1, `RST_F_M1, `RST_K_M1, `RST_M_M1, `RST_N_M1,
                      `RST_NP_M1, `RST_SUBCLASS, `RST_S_M1, `RST_JESDV, `RST_HD};
         config_error <= 1'b0;
         samples <= '0;
         samples_valid <= 1'b0;
      end else begin
         map_cfg <= next_map_cfg;
         config_error <= next_config_error;
         samples <= next_samples;
         samples_valid <= rd_pending;
      end
   end
endmodule

/* File: verification/rx_latency_props.sv */
// Checker of the receive latency and transport block, bound to its top module
`timescale 1ns/1ps
`include "rx_latency_defines.svh"
module rx_latency_props
   import rx_latency_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic lmfc_edge,
   input wire logic [4:0] cfg_cf,
   input wire logic [1:0] cfg_cs,
   input wire logic local_multiframe_clock,
   input wire logic samples_valid,
   input wire samples_t samples,
   input wire logic config_error,
   input wire logic buffer_underrun
);
   logic [2:0] phase, phase_now;
   logic seen, link_en, armed;
   logic [7:0] mf_del;
   logic [3:0] rbd;
   logic [15:0] hist;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Shadow of multiframe phase and settings; assumes one octet per frame, so eight cycles per multiframe
   assign phase_now = lmfc_edge ? 3'h0 : phase;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 3'h0;
         seen <= 1'b0;
         link_en <= 1'b0;
         armed <= 1'b0;
         mf_del <= 8'h00;
         rbd <= 4'h0;
         hist <= 16'h0000;
      end else begin
         phase <= phase_now + 3'h1;
         seen <= seen | lmfc_edge;
         hist <= {hist[14:0], local_multiframe_clock};
         if (reg_wr && reg_addr == `OFS_LINK_CTRL) begin
            link_en <= reg_wdata[0];
            armed <= reg_wdata[0] & ~link_en;
         end else if (samples_valid) begin
            armed <= 1'b0;
         end
         if (reg_wr && reg_addr == `OFS_MF_DELAY) begin
            mf_del <= reg_wdata;
         end
         // Settings above ten saturate, so the shadow never indexes past the history
         if (reg_wr && reg_addr == `OFS_DELAY_VAR) begin
            rbd <= (reg_wdata > `RBD_MAX) ? 4'hA : reg_wdata[3:0];
         end
      end
   end
   a_unmapped_read: assert property (reg_addr == 12'h301 |=> reg_rdata == 8'h00)
      else $error("unmapped register read not zero");
   a_delay_readback: assert property ((reg_wr && reg_addr == `OFS_MF_DELAY) ##1
      (reg_addr == `OFS_MF_DELAY && !reg_wr) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("multiframe delay readback differs from write");
   a_pulse_phase: assert property (local_multiframe_clock |-> link_en && seen && phase_now == mf_del[2:0])
      else $error("local multiframe pulse at wrong phase");
   a_pulse_present: assert property (link_en && seen && phase_now == mf_del[2:0] |-> local_multiframe_clock)
      else $error("local multiframe pulse missing");
   a_release_delay: assert property (samples_valid && armed |-> hist[rbd + 4'h2])
      else $error("first release not at pulse plus buffer delay");
   a_valid_enabled: assert property (samples_valid |-> $past(link_en))
      else $error("samples released while link disabled");
   a_samples_hold: assert property (!samples_valid |-> $stable(samples))
      else $error("samples changed without valid");
   a_bad_ctrl_error: assert property ((cfg_cf != 5'h00 || cfg_cs != 2'h0) [*2] |-> config_error)
      else $error("control words or bits not flagged");
   a_flush_clear: assert property ($fell(link_en) |=> ##1 (!buffer_underrun && !samples_valid) [*3])
      else $error("disable did not flush the stream");
   c_first_release: cover property (samples_valid && armed);
   c_underrun: cover property ($rose(buffer_underrun));
   c_cfg_error: cover property ($rose(config_error));
endmodule
bind rx_latency_transport rx_latency_props i_rx_latency_props (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lmfc_edge(lmfc_edge), .cfg_cf(cfg_cf),
   .cfg_cs(cfg_cs), .local_multiframe_clock(local_multiframe_clock), .samples_valid(samples_valid),
   .samples(samples), .config_error(config_error), .buffer_underrun(buffer_underrun));

/* File: verification/jesd_tx_model.sv */
// Behavioural transmitter that feeds eight skewed lanes of one-octet frames
`timescale 1ns/1ps
module jesd_tx_model
   import rx_latency_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic go,
   output logic [7:0] lane_valid,
   output lane_words_t lane_data
);
   logic [7:0][1:0] wait_cnt;
   logic [7:0][2:0] word_cnt;
   // Lane l starts l mod 3 cycles late; skew stays well inside one multiframe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_cnt <= '0;
         word_cnt <= '0;
         lane_valid <= '0;
      end else begin
         for (int l = 0; l < 8; l++) begin
            wait_cnt[l] <= !go ? 2'h0 : (wait_cnt[l] == 2'(l % 3)) ? wait_cnt[l] : wait_cnt[l] + 2'h1;
            lane_valid[l] <= go && wait_cnt[l] == 2'(l % 3);
            word_cnt[l] <= !go ? 3'h0 : word_cnt[l] + 3'(lane_valid[l]);
         end
      end
   end
   // Pure sample octets, split across lanes; idle lanes show the inverse so stale data never looks valid
   always_comb begin
      for (int l = 0; l < 8; l++) begin
         for (int o = 0; o < 4; o++) begin
            lane_data[l][31 - 8 * o -: 8] = {word_cnt[l], 3'(l), 2'(o)} ^ {8{~lane_valid[l]}};
         end
      end
   end
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the receive latency and transport block
`timescale 1ns/1ps
`include "rx_latency_defines.svh"
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb
   import rx_latency_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b, reg_wr, go, local_multiframe_clock, samples_valid, config_error, buffer_underrun;
   logic lmfc_edge = 1'b0;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, lane_valid, seen_l;
   logic [4:0] cfg_cf;
   logic [1:0] cfg_cs;
   lane_words_t lane_data;
   samples_t samples;
   int cyc, err_total, tests_run, sv_n, sv_first, arr, v0, mi;
   int lane_min_delay = 1;
   int lane_max_delay = 1;
   rx_latency_transport i_rx_latency_transport (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lmfc_edge(lmfc_edge), .cfg_cf(cfg_cf),
      .cfg_cs(cfg_cs), .lane_valid(lane_valid), .lane_data(lane_data),
      .local_multiframe_clock(local_multiframe_clock), .samples_valid(samples_valid), .samples(samples),
      .config_error(config_error), .buffer_underrun(buffer_underrun));
   jesd_tx_model i_jesd_tx_model (.clk(clk), .rst_b(rst_b), .go(go), .lane_valid(lane_valid),
      .lane_data(lane_data));
   always #50 clk = ~clk;
   // Aligned multiframe edge every eight cycles, launched on the edge itself
   always @(posedge clk) begin
      cyc <= cyc + 1;
      lmfc_edge <= ((cyc + 1) % 8 == 0);
   end
   // Eight lanes, one octet per frame, two samples per converter: lanes 2k and 2k+1 form sample k
   function automatic logic [15:0] exp_smp(input int c, input int i, input int n);
      int idx;
      idx = c * 2 + i % 2;
      return {n[2:0], 3'(2 * idx), 2'(i / 2), n[2:0], 3'(2 * idx + 1), 2'(i / 2)};
   endfunction
   // Record arrival, first release and the first sample sets of each stream
   always @(posedge clk) begin
      if (go && v0 < 0 && lane_valid[0] === 1'b1) begin
         v0 = cyc;
      end
      seen_l = seen_l | lane_valid;
      if (arr < 0 && seen_l === 8'hFF) begin
         arr = cyc;
      end
      if (samples_valid === 1'b1) begin
         if (sv_n == 0) begin
            sv_first = cyc;
         end
         for (mi = 0; mi < 8 && sv_n < 4; mi++) begin
            `CHECK("converter 0 sample", exp_smp(0, mi, sv_n), samples.c0[mi])
            `CHECK("converter 1 sample", exp_smp(1, mi, sv_n), samples.c1[mi])
         end
         sv_n = sv_n + 1;
      end
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic expire(input bit ok, input string what);
      if (!ok) begin
         err_total++;
         $display("[FAIL] %s expected done seen timeout", what);
         print_verdict();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 reg_addr = a;
      @(posedge clk);
      #1 `CHECK("register read", e, reg_rdata)
   endtask
   task automatic cfg(input logic [11:0] a, input logic [7:0] d, input logic e);
      wr(a, d);
      tick(2);
      `CHECK("config error", e, config_error)
   endtask
   task automatic pins(input logic [4:0] cf, input logic [1:0] cs, input logic e);
      cfg_cf = cf;
      cfg_cs = cs;
      tick(3);
      `CHECK("control pins error", e, config_error)
   endtask
   // One stream: program delays, enable, feed skewed lanes, check release, latency and underrun
   task automatic run_stream(input logic [7:0] d, input logic [7:0] v);
      int k, p;
      wr(`OFS_DELAY_VAR, v);
      wr(`OFS_MF_DELAY, d);
      rd_chk(`OFS_MF_DELAY, d);
      wr(`OFS_LINK_CTRL, 8'h01);
      tick(8);
      // Start away from the local pulse phase so arrival never meets the pulse in the same cycle
      for (k = 0; k < 8 && cyc % 8 != (d + 3) % 8; k++) tick(1);
      sv_n = 0;
      arr = -1;
      v0 = -1;
      seen_l = 8'h00;
      go = 1'b1;
      for (k = 0; k < 200 && sv_n < 6; k++) tick(1);
      expire(sv_n >= 6, "release");
      p = arr + 1;
      while (p % 8 != d % 8) p++;
      `CHECK("release cycle", p + 3 + ((v > 8'h0A) ? 10 : int'(v)), sv_first)
      rd_chk(`OFS_LATENCY, 8'((v0 - d % 8 + 8) % 8));
      wr(`OFS_LATENCY, 8'hFF);
      rd_chk(`OFS_LATENCY, 8'((v0 - d % 8 + 8) % 8));
      go = 1'b0;
      for (k = 0; k < 40 && buffer_underrun !== 1'b1; k++) tick(1);
      expire(buffer_underrun === 1'b1, "underrun");
      wr(`OFS_LINK_CTRL, 8'h00);
      tick(3);
      `CHECK("underrun cleared", 1'b0, buffer_underrun)
      $display("stream test done, delay %0h variation %0h", d, v);
   endtask
   initial begin
      rst_b = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      cfg_cf = 5'h00;
      cfg_cs = 2'h0;
      go = 1'b0;
      err_total = 0;
      tests_run = 0;
      tick(8);
      rst_b = 1'b1;
      rd_chk(`OFS_LINK_CTRL, 8'h00);
      rd_chk(`OFS_MF_DELAY, 8'h00);
      rd_chk(`OFS_DELAY_VAR, 8'h00);
      rd_chk(12'h301, 8'h00);
      rd_chk(`OFS_NP_SUBCLASS, 8'h2F);
      rd_chk(`OFS_HD, 8'h80);
      `CHECK("reset config error", 1'b0, config_error)
      $display("register reset test done");
      run_stream(8'h0B, 8'h0C);
      run_stream(8'((lane_min_delay - 1) % 32), 8'((lane_max_delay + 1) - (lane_min_delay - 1)));
      cfg(`OFS_L_M1, 8'h03, 1'b1);
      cfg(`OFS_S_JESDV, 8'h20, 1'b0);
      cfg(`OFS_F_M1, 8'h01, 1'b1);
      cfg(`OFS_HD, 8'h00, 1'b1);
      cfg(`OFS_S_JESDV, 8'h21, 1'b0);
      cfg(`OFS_K_M1, 8'h0F, 1'b1);
      cfg(`OFS_K_M1, 8'h1F, 1'b0);
      cfg(`OFS_M_M1, 8'h02, 1'b1);
      cfg(`OFS_M_M1, 8'h01, 1'b0);
      cfg(`OFS_N_M1, 8'h0B, 1'b1);
      cfg(`OFS_N_M1, 8'h0F, 1'b0);
      cfg(`OFS_NP_SUBCLASS, 8'h2B, 1'b1);
      cfg(`OFS_NP_SUBCLASS, 8'h2F, 1'b0);
      cfg(`OFS_F_M1, 8'h03, 1'b1);
      cfg(`OFS_F_M1, 8'h00, 1'b1);
      cfg(`OFS_HD, 8'h80, 1'b1);
      cfg(`OFS_L_M1, 8'h07, 1'b0);
      pins(5'h01, 2'h0, 1'b1);
      pins(5'h00, 2'h1, 1'b1);
      pins(5'h00, 2'h0, 1'b0);
      $display("configuration test done");
      print_verdict();
   end
endmodule
